//--- cell_pack_model.sv
// partner model: cell, charger and load as seen through the sense comparators
module cell_pack_model (
    // clock
    input  wire logic clk,
    // flags toward the protection logic
    output logic      aboveOvercharge,
    output logic      aboveOverchargeRelease,
    output logic      belowOverdischarge,
    output logic      aboveOverdischargeRelease,
    output logic      dischargeAboveLevel1,
    output logic      dischargeAboveLevel2,
    output logic      dischargeAboveShort,
    output logic      chargeAboveThreshold,
    output logic      overTemp,
    output logic      belowThermalRecovery,
    output logic      chargerPresent,
    output logic      loadPresent,
    output logic      charging
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [12:0] flagsReg = 13'h0208;
    // comparators give levels; the start value is a cool healthy cell, nothing attached
    assign {aboveOvercharge, aboveOverchargeRelease, belowOverdischarge, aboveOverdischargeRelease,
        dischargeAboveLevel1, dischargeAboveLevel2, dischargeAboveShort, chargeAboveThreshold,
        overTemp, belowThermalRecovery, chargerPresent, loadPresent, charging} = flagsReg;
    // a new pack condition lands just after an edge, so the edge before still sees the old one
    task automatic set_pack(input logic [12:0] flags);
        @(posedge clk);
        #1 flagsReg = flags;
    endtask
endmodule

//--- cell_protection_monitor.sv
// checker: timing relations on the cell protection top ports
module cell_protection_monitor
    import prot_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sense flags
    input wire logic aboveOvercharge,
    input wire logic aboveOverchargeRelease,
    input wire logic belowOverdischarge,
    input wire logic aboveOverdischargeRelease,
    input wire logic dischargeAboveLevel1,
    input wire logic dischargeAboveLevel2,
    input wire logic dischargeAboveShort,
    input wire logic chargeAboveThreshold,
    input wire logic overTemp,
    input wire logic belowThermalRecovery,
    input wire logic chargerPresent,
    input wire logic loadPresent,
    input wire logic charging,
    // outputs
    input wire logic switchEnable,
    input wire logic powerDown
);
    logic [13:0] shortCnt;
    logic        calm;
    // run length of a loaded short; saturates so a long run never wraps back to zero
    always_ff @(posedge clk) begin
        if (rst || !(dischargeAboveShort && loadPresent)) shortCnt <= 14'h0000;
        else if (shortCnt != 14'h3fff) shortCnt <= shortCnt + 14'h0001;
    end
    // every release condition met and no detector busy
    assign calm = !aboveOverchargeRelease && aboveOverdischargeRelease && !belowOverdischarge && !loadPresent
        && !chargerPresent && belowThermalRecovery && !overTemp && !chargeAboveThreshold
        && !dischargeAboveLevel1 && !dischargeAboveLevel2 && !dischargeAboveShort;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_short_trip: assert property (shortCnt > 14'(ShortCycles) |-> !switchEnable)
        else $error("switch still on after a long short");
    a_temp_off: assert property (overTemp |=> !switchEnable)
        else $error("switch on during over temperature");
    a_therm_dis_hold: assert property ($rose(overTemp) && !charging ##1
        !(belowThermalRecovery && !loadPresent) [*4] |=> !switchEnable)
        else $error("discharge thermal shutdown released early");
    a_therm_chg_hold: assert property ($rose(overTemp) && charging ##1
        !(belowThermalRecovery && !chargerPresent) [*4] |=> !switchEnable)
        else $error("charge thermal shutdown released early");
    a_down_switch_off: assert property (powerDown |-> !switchEnable)
        else $error("switch on in power down");
    a_down_release: assert property (powerDown && aboveOverdischargeRelease |=> !powerDown)
        else $error("power down kept above release level");
    a_down_charger: assert property (powerDown && chargerPresent && !belowOverdischarge |=> !powerDown)
        else $error("power down kept with charger attached");
    a_down_entry: assert property ($rose(powerDown) |-> $past(belowOverdischarge))
        else $error("power down without low cell");
    a_calm_on: assert property (calm [*2] |=> switchEnable)
        else $error("switch off with no protection cause");
    a_reset_clear: assert property ($fell(rst) |-> switchEnable && !powerDown)
        else $error("state not cleared by reset");
endmodule
bind cell_protection_state_machine cell_protection_monitor i_cell_protection_monitor (.*);

//--- cell_protection_state_machine.sv
// top of the single cell protection logic: latched protection states and switch control

module cell_protection_state_machine (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // cell voltage comparator flags
    input  wire logic aboveOvercharge,
    input  wire logic aboveOverchargeRelease,
    input  wire logic belowOverdischarge,
    input  wire logic aboveOverdischargeRelease,
    // current comparator flags
    input  wire logic dischargeAboveLevel1,
    input  wire logic dischargeAboveLevel2,
    input  wire logic dischargeAboveShort,
    input  wire logic chargeAboveThreshold,
    // temperature flags
    input  wire logic overTemp,
    input  wire logic belowThermalRecovery,
    // pack terminal sensing
    input  wire logic chargerPresent,
    input  wire logic loadPresent,
    input  wire logic charging,
    // outputs
    output logic      switchEnable,
    output logic      powerDown
);
    import prot_pkg::*;

    // every latched protection state lives in one word, cleared together by reset
    typedef struct packed {
        logic         overcharge;
        logic         overdischarge;
        logic         dischargeOc;
        logic         chargeOc;
        therm_state_t therm;
        logic         switchEn;
        logic         pwrDown;
    } ctrl_state_t;

    ctrl_state_t stateReg;
    ctrl_state_t stateNext;
    delay_if     dly ();

    // set terms: an expiry is honoured only while its comparator still agrees, so
    // a timer flag that lags the input by one cycle cannot outvote a release
    logic        setOvercharge;
    logic        setOverdischarge;
    logic        oc1Trip;
    logic        oc2Trip;
    logic        shortTrip;
    logic        setDischargeOc;
    logic        setChargeOc;
    // release terms, one per way out of a protection state
    logic        relOverchargeSelf;
    logic        relOverchargeLoad;
    logic        relOverdischargeCell;
    logic        relOverdischargeCharge;
    logic        relDischargeOc;
    logic        relChargeOc;
    logic        relThermDischarge;
    logic        relThermCharge;

    ////////////////////////////////////////////////////////////////////////////
    // timer conditions: each timer qualifies only while its comparator is true
    // a level that drops restarts only its own timer, never another's
    always_comb begin
        dly.qualify               = '0;
        dly.qualify[TmrOvervolt]  = aboveOvercharge;
        dly.qualify[TmrUndervolt] = belowOverdischarge;
        dly.qualify[TmrOc1]       = dischargeAboveLevel1;
        dly.qualify[TmrOc2]       = dischargeAboveLevel2;
        dly.qualify[TmrShort]     = dischargeAboveShort;
        dly.qualify[TmrChargeOc]  = chargeAboveThreshold;
    end

    // one bank of timers, one channel per detection
    delay_timers timers (
        .clk (clk),
        .rst (rst),
        .dly (dly)
    );

    ////////////////////////////////////////////////////////////////////////////
    // per level discharge trips: each current level has its own timer and any
    // one of them is enough; the short level is the fastest and usually wins
    always_comb begin
        oc1Trip   = dly.expired[TmrOc1] && dischargeAboveLevel1;
        oc2Trip   = dly.expired[TmrOc2] && dischargeAboveLevel2;
        shortTrip = dly.expired[TmrShort] && dischargeAboveShort;
    end

    // voltage and charge side trips, gated by the live level in the same way
    always_comb begin
        setOvercharge    = dly.expired[TmrOvervolt] && aboveOvercharge;
        setOverdischarge = dly.expired[TmrUndervolt] && belowOverdischarge;
        setDischargeOc   = oc1Trip || oc2Trip || shortTrip;
        setChargeOc      = dly.expired[TmrChargeOc] && chargeAboveThreshold;
    end

    // release terms: none of them waits on a timer
    always_comb begin
        relOverchargeSelf      = !aboveOverchargeRelease;
        relOverchargeLoad      = !aboveOvercharge && loadPresent;
        relOverdischargeCell   = aboveOverdischargeRelease;
        relOverdischargeCharge = chargerPresent && !belowOverdischarge;
        relDischargeOc         = !loadPresent;
        relChargeOc            = !chargerPresent;
        relThermDischarge      = belowThermalRecovery && !loadPresent;
        relThermCharge         = belowThermalRecovery && !chargerPresent;
    end

    ////////////////////////////////////////////////////////////////////////////
    // protection state updates; releases are checked before sets so that a
    // fresh detection in the same cycle wins
    always_comb begin
        stateNext = stateReg;

        // overcharge
        // either release path clears it; a fresh expiry in the same cycle still wins
        if (relOverchargeSelf) begin
            stateNext.overcharge = 1'b0;
        end else if (relOverchargeLoad) begin
            stateNext.overcharge = 1'b0;
        end
        if (setOvercharge) begin
            stateNext.overcharge = 1'b1;
        end

        // overdischarge: release needs no delay
        // the charger path lets a depleted cell take charge again
        if (relOverdischargeCell) begin
            stateNext.overdischarge = 1'b0;
        end else if (relOverdischargeCharge) begin
            stateNext.overdischarge = 1'b0;
        end
        if (setOverdischarge) begin
            stateNext.overdischarge = 1'b1;
        end

        // discharge overcurrent, any of three levels
        // the levels share one latched state: the switch cannot tell which fired
        if (relDischargeOc) begin
            stateNext.dischargeOc = 1'b0;
        end
        if (setDischargeOc) begin
            stateNext.dischargeOc = 1'b1;
        end

        // charge overcurrent
        // its delay is borrowed from the first discharge level
        if (relChargeOc) begin
            stateNext.chargeOc = 1'b0;
        end
        if (setChargeOc) begin
            stateNext.chargeOc = 1'b1;
        end

        // thermal shutdown remembers direction for its release condition
        // a pack that swaps direction while still hot keeps its first release rule
        case (stateReg.therm)
            THERM_IDLE: begin
                if (overTemp) begin
                    stateNext.therm = charging ? THERM_CHARGE : THERM_DISCHARGE;
                end
            end
            THERM_DISCHARGE: begin
                if (relThermDischarge) begin
                    stateNext.therm = THERM_IDLE;
                end
            end
            THERM_CHARGE: begin
                if (relThermCharge) begin
                    stateNext.therm = THERM_IDLE;
                end
            end
            default: begin
                stateNext.therm = THERM_IDLE;
            end
        endcase

        // single switch: any protection turns it off
        stateNext.switchEn = !(stateNext.overcharge || stateNext.overdischarge ||
                               stateNext.dischargeOc || stateNext.chargeOc ||
                               stateNext.therm != THERM_IDLE);
        stateNext.pwrDown  = stateNext.overdischarge;
    end

    // register; after reset the switch follows inputs since all states are clear
    // reset is synchronous, so a glitch between edges cannot clear a protection
    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg          <= '0;
            stateReg.therm    <= THERM_IDLE;
            stateReg.switchEn <= 1'b1;
        end else begin
            stateReg <= stateNext;
        end
    end

    // both outputs come straight from the state register
    assign switchEnable = stateReg.switchEn;
    assign powerDown    = stateReg.pwrDown;
endmodule

//--- delay_if.sv
// interface carrying qualify conditions and held expiry flags between the controller and its timers
interface delay_if;
    import prot_pkg::*;
    logic [NumTimers-1:0] qualify;
    logic [NumTimers-1:0] expired;
    modport ctrl (output qualify, input expired);
    modport tmr  (input qualify, output expired);
endinterface

//--- delay_timers.sv
// bank of detection delay timers, one per protection channel
module delay_timers
    import prot_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // conditions and expiry
    delay_if.tmr      dly
);
    typedef struct packed {
        logic [NumTimers-1:0][TimerWidth-1:0] count;
        logic [NumTimers-1:0]                 expired;
    } timer_state_t;

    timer_state_t stateReg;
    timer_state_t stateNext;

    localparam logic [NumTimers-1:0][TimerWidth-1:0] Limit = {
        TimerWidth'(ChargeOcCycles), TimerWidth'(ShortCycles), TimerWidth'(Oc2Cycles),
        TimerWidth'(Oc1Cycles), TimerWidth'(UndervoltCycles), TimerWidth'(OvervoltCycles)};

    ////////////////////////////////////////////////////////////////////////////
    // count while qualified, restart on any drop
    always_comb begin
        stateNext = stateReg;
        for (int i = 0; i < NumTimers; i++) begin
            if (!dly.qualify[i]) begin
                stateNext.count[i]   = '0;
                stateNext.expired[i] = 1'b0;
            end else if (stateReg.count[i] >= Limit[i] - TimerWidth'(1)) begin
                stateNext.expired[i] = 1'b1; // held while condition lasts
            end else begin
                stateNext.count[i] = stateReg.count[i] + TimerWidth'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign dly.expired = stateReg.expired;
endmodule

//--- prot_pkg.sv
// package: timing counts, timer channel indices and state encodings for the cell protection logic
package prot_pkg;
    // clock rate
    localparam int unsigned ClkHz = 50_000_000;

    // delay figures in their own units
    localparam int unsigned OvervoltDelayMs    = 130;
    localparam int unsigned UndervoltDelayMs   = 40;
    localparam int unsigned Oc1DelayMs         = 10;
    localparam int unsigned Oc2DelayMs         = 3;
    localparam int unsigned ShortDelayUs       = 150;
    // charge overcurrent borrows the first discharge overcurrent delay
    localparam int unsigned ChargeOcDelayMs    = Oc1DelayMs;

    // delays in clock cycles, derived from the rate
    localparam int unsigned OvervoltCycles = OvervoltDelayMs * (ClkHz / 1000);
    localparam int unsigned UndervoltCycles = UndervoltDelayMs * (ClkHz / 1000);
    localparam int unsigned Oc1Cycles      = Oc1DelayMs * (ClkHz / 1000);
    localparam int unsigned Oc2Cycles      = Oc2DelayMs * (ClkHz / 1000);
    localparam int unsigned ShortCycles    = ShortDelayUs * (ClkHz / 1_000_000);
    localparam int unsigned ChargeOcCycles = ChargeOcDelayMs * (ClkHz / 1000);

    // timer width covers the longest delay
    localparam int unsigned TimerWidth = 23;

    // timer channel indices
    localparam int unsigned NumTimers = 6;
    localparam int unsigned TmrOvervolt  = 0;
    localparam int unsigned TmrUndervolt = 1;
    localparam int unsigned TmrOc1       = 2;
    localparam int unsigned TmrOc2       = 3;
    localparam int unsigned TmrShort     = 4;
    localparam int unsigned TmrChargeOc  = 5;

    // thermal recovery level, informative only: the comparator gives the flag
    localparam int unsigned ThermalRecoveryLevelC = 100;

    // thermal shutdown record: which direction caused it
    typedef enum logic [2:0] {
        THERM_IDLE      = 3'b001,
        THERM_DISCHARGE = 3'b010,
        THERM_CHARGE    = 3'b100
    } therm_state_t;
endpackage

//--- testbench.sv
// testbench: short circuit, thermal, early trip and reset scenarios for the protection logic
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic aboveOvercharge, aboveOverchargeRelease, belowOverdischarge, aboveOverdischargeRelease;
    logic dischargeAboveLevel1, dischargeAboveLevel2, dischargeAboveShort, chargeAboveThreshold;
    logic overTemp, belowThermalRecovery, chargerPresent, loadPresent, charging;
    logic switchEnable, powerDown;
    int   nErrors = 0;
    int   nTests = 0;
    cell_protection_state_machine i_cell_protection_state_machine (.*);
    cell_pack_model i_cell_pack_model (.*);
    // free running 50 MHz clock
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic check(input string name, input logic exp, input logic got);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // short one cycle below its delay must not trip, the full delay must, load removal frees it
    task automatic t_short;
        i_cell_pack_model.set_pack(13'h03ca);
        cycles(7498);
        i_cell_pack_model.set_pack(13'h020a);
        cycles(2);
        check("switchEnable", 1'b1, switchEnable);
        i_cell_pack_model.set_pack(13'h03ca);
        cycles(7500);
        check("switchEnable", 1'b1, switchEnable);
        cycles(1);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h0208);
        cycles(1);
        check("switchEnable", 1'b1, switchEnable);
    endtask
    // hot while discharging: cooling alone is not enough, the load must go too
    task automatic t_therm_dis;
        i_cell_pack_model.set_pack(13'h0212);
        cycles(1);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h0202);
        cycles(3);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h020a);
        cycles(3);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h0208);
        cycles(1);
        check("switchEnable", 1'b1, switchEnable);
    endtask
    // hot while charging: cool with the charger still on keeps the switch off
    task automatic t_therm_chg;
        i_cell_pack_model.set_pack(13'h0215);
        cycles(1);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h020d);
        cycles(3);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h0208);
        cycles(1);
        check("switchEnable", 1'b1, switchEnable);
        check("powerDown", 1'b0, powerDown);
    endtask
    // conditions held far short of their delays must leave the switch on and power down clear
    task automatic t_no_early;
        i_cell_pack_model.set_pack(13'h1a08);
        cycles(1000);
        check("switchEnable", 1'b1, switchEnable);
        i_cell_pack_model.set_pack(13'h0408);
        cycles(1000);
        check("switchEnable", 1'b1, switchEnable);
        check("powerDown", 1'b0, powerDown);
        i_cell_pack_model.set_pack(13'h022d);
        cycles(1000);
        check("switchEnable", 1'b1, switchEnable);
        i_cell_pack_model.set_pack(13'h030a);
        cycles(1000);
        check("switchEnable", 1'b1, switchEnable);
        i_cell_pack_model.set_pack(13'h028a);
        cycles(1000);
        check("switchEnable", 1'b1, switchEnable);
        i_cell_pack_model.set_pack(13'h0208);
        cycles(1);
        check("switchEnable", 1'b1, switchEnable);
    endtask
    // reset in mid-run clears a held thermal shutdown even with the load still on
    task automatic t_reset;
        i_cell_pack_model.set_pack(13'h0212);
        cycles(1);
        check("switchEnable", 1'b0, switchEnable);
        i_cell_pack_model.set_pack(13'h0202);
        cycles(2);
        check("switchEnable", 1'b0, switchEnable);
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        cycles(1);
        check("switchEnable", 1'b1, switchEnable);
        check("powerDown", 1'b0, powerDown);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        cycles(1);
        check("switchEnable", 1'b1, switchEnable);
        check("powerDown", 1'b0, powerDown);
        t_short();
        t_therm_dis();
        t_therm_chg();
        t_no_early();
        t_reset();
        stop_test();
    end
    // watchdog: the scenarios need about 20100 cycles
    initial begin
        #(20 * 40000);
        nErrors++;
        stop_test();
    end
endmodule
